// [common/fault_status_pkg.sv]
// Constants for the fault and warning status register bank
package fault_status_pkg;

    // ------------------------------------------------------------------
    // Command codes of the status registers
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SUMMARY_LOW  = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_HIGH = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL  = 8'h7A;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_SUMMARY_DETAIL  = 8'h7B;

    // ------------------------------------------------------------------
    // Summary high byte fields
    // ------------------------------------------------------------------
    localparam int HI_OUTPUT_VOLTAGE_SUMMARY_BIT   = 7;
    localparam int HI_OUTPUT_CURRENT_SUMMARY_BIT   = 6;
    localparam int HI_BIAS_BIT   = 5;
    localparam int HI_POWER_GOOD_LOW_FLAG_BIT  = 3;

    // ------------------------------------------------------------------
    // Summary low byte fields
    // ------------------------------------------------------------------
    localparam int LO_OFF_BIT    = 6;
    localparam int LO_OV_BIT     = 5;
    localparam int LO_OC_BIT     = 4;
    localparam int LO_VIN_UV_BIT = 3;
    localparam int LO_TEMP_BIT   = 2;
    localparam int LO_CML_BIT    = 1;
    localparam int LO_OTHER_BIT  = 0;

    // ------------------------------------------------------------------
    // Detail register fields
    // ------------------------------------------------------------------
    localparam int VD_OVF_BIT    = 7;
    localparam int VD_OVW_BIT    = 6;
    localparam int VD_UVW_BIT    = 5;
    localparam int VD_UVF_BIT    = 4;
    localparam int ID_OCF_BIT    = 7;
    localparam int ID_OVERCURRENT_WITH_UNDERVOLTAGE_FLAG_BIT  = 6;
    localparam int ID_UCF_BIT    = 4;

    // ------------------------------------------------------------------
    // Fault event input vector positions
    // ------------------------------------------------------------------
    localparam int EV_OVF        = 0;
    localparam int EV_OVW        = 1;
    localparam int EV_UVW        = 2;
    localparam int EV_UVF        = 3;
    localparam int EV_OCP        = 4;
    localparam int EV_OCN        = 5;
    localparam int EV_BIAS_UV    = 6;
    localparam int EV_TEMP       = 7;
    localparam int EV_MEM_LOGIC  = 8;
    localparam int EV_OTHER      = 9;
    localparam int EV_POWER_GOOD_LOW_FLAG_PIN  = 10;
    localparam int EV_COUNT      = 11;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]          BYTE_RESET  = 8'h00;
    localparam logic [EV_COUNT-1:0] SYNC_RESET  = 11'h000;
    localparam logic                FLAG_RESET  = 1'b0;

endpackage

// [core/fault_status_regs.sv]
// Fault and warning status register bank with command-code read port
//
// Contract
// - High bit 7: any output voltage fault/warning
// - High bit 6: output current fault
// - High bit 5: bias supply voltage fault
// - High bit 3: one while power-good pin low
// - Low bit 6 zero while output driven
// - Off bit set when commanded off/tri-stated
// - Low bit 5: output overvoltage fault
// - Low bit 4: output overcurrent fault
// - Low bit 3: input undervoltage fault (code: reads the bias supply fault flag, as high bit 5 does)
// - Low bit 2: temperature fault or warning
// - Low bit 1: communication, memory, logic fault
// - Low bit 0: any other fault/warning
// - Voltage detail bit 7: overvoltage fault
// - Voltage detail bit 6: overvoltage warning
// - Voltage detail bit 5: undervoltage warning
// - Voltage detail bit 4: undervoltage fault
// - Current detail bit 7: positive overcurrent
// - Current detail bit 6: overcurrent plus undervoltage
// - Current detail bit 4: negative overcurrent
// - All status bits ignore host writes
// - Unsupported command code sets command fault
`timescale 1ns/1ps
module fault_status_regs
    import fault_status_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_b_i,
    // Fault detector and pin levels, asynchronous
    input  wire logic [fault_status_pkg::EV_COUNT-1:0] event_i,
    // Output state from the power stage control, same clock
    input  wire logic                                 commanded_on_i,
    input  wire logic                                 output_tristated_i,
    // Command port from the bus protocol engine, same clock
    input  wire logic                                 cmd_valid_i,
    input  wire logic                                 cmd_write_i,
    input  wire logic [7:0]                           cmd_code_i,
    input  wire logic [7:0]                           cmd_wdata_i,
    input  wire logic                                 cmd_known_elsewhere_i,
    input  wire logic                                 clear_faults_i,
    // Read answer and flags
    output logic [7:0]                                rd_data_o,
    output logic                                      rd_valid_o,
    output logic                                      cmd_claimed_o,
    output logic                                      command_fault_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_meta_nxt;
    logic rst_sync_r;
    logic rst_sync_nxt;
    logic rst_b;

    // Two edges of release, so no flop leaves reset on a runt edge
    always_comb begin
        rst_meta_nxt = 1'b1;
        rst_sync_nxt = rst_meta_r;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_r <= FLAG_RESET;
            rst_sync_r <= FLAG_RESET;
        end else begin
            rst_meta_r <= rst_meta_nxt;
            rst_sync_r <= rst_sync_nxt;
        end
    end

    assign rst_b = rst_sync_r;

    // ------------------------------------------------------------------
    // Event synchronisers
    // ------------------------------------------------------------------
    // Detectors are analog and asynchronous; only the last stage is read.
    logic [EV_COUNT-1:0] sync_r [SYNC_STAGES];
    logic [EV_COUNT-1:0] sync_nxt [SYNC_STAGES];
    logic [EV_COUNT-1:0] ev;

    always_comb begin
        sync_nxt[0] = event_i;
        for (int s = 1; s < SYNC_STAGES; s++) begin
            sync_nxt[s] = sync_r[s-1];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                sync_r[s] <= SYNC_RESET;
            end
        end else begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                sync_r[s] <= sync_nxt[s];
            end
        end
    end

    assign ev = sync_r[SYNC_STAGES-1];

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic bad_cmd;
    logic claimed;

    always_comb begin
        // Only the four status codes belong to this bank
        unique case (cmd_code_i)
            CMD_SUMMARY_LOW,
            CMD_SUMMARY_HIGH,
            CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL,
            CMD_OUTPUT_CURRENT_SUMMARY_DETAIL: claimed = 1'b1;
            default:         claimed = 1'b0;
        endcase
        // Codes that another block owns are not faults here
        bad_cmd = cmd_valid_i && !claimed && !cmd_known_elsewhere_i;
    end

    // ------------------------------------------------------------------
    // Latched fault flags
    // ------------------------------------------------------------------
    // Bit positions inside the packed flag vector;
    // the package names the register fields, these are internal
    localparam int FL_OVF   = 0;
    localparam int FL_OVW   = 1;
    localparam int FL_UVW   = 2;
    localparam int FL_UVF   = 3;
    localparam int FL_OCP   = 4;
    localparam int FL_OCUV  = 5;
    localparam int FL_OCN   = 6;
    localparam int FL_BIAS  = 7;
    localparam int FL_TEMP  = 8;
    localparam int FL_MEM   = 9;
    localparam int FL_OTHER = 10;
    localparam int FL_CMD   = 11;
    localparam int FL_COUNT = 12;

    logic overvoltage_fault_flag_r;
    logic overvoltage_warning_flag_r;
    logic undervoltage_warning_flag_r;
    logic undervoltage_fault_flag_r;
    logic positive_overcurrent_flag_r;
    logic overcurrent_with_undervoltage_flag_r;
    logic negative_overcurrent_flag_r;
    logic bias_fault_r;
    logic temp_fault_r;
    logic mem_logic_fault_r;
    logic other_fault_r;
    logic cmd_fault_r;
    logic [FL_COUNT-1:0] flags_r;
    logic [FL_COUNT-1:0] flags_nxt;
    logic [FL_COUNT-1:0] flag_set;

    // Set wins over clear, so an event in the clear cycle survives
    always_comb begin
        flag_set           = '0;
        flag_set[FL_OVF]   = ev[EV_OVF];
        flag_set[FL_OVW]   = ev[EV_OVW];
        flag_set[FL_UVW]   = ev[EV_UVW];
        flag_set[FL_UVF]   = ev[EV_UVF];
        flag_set[FL_OCP]   = ev[EV_OCP];
        flag_set[FL_OCUV]  = ev[EV_OCP] && ev[EV_UVF];
        flag_set[FL_OCN]   = ev[EV_OCN];
        flag_set[FL_BIAS]  = ev[EV_BIAS_UV];
        flag_set[FL_TEMP]  = ev[EV_TEMP];
        flag_set[FL_MEM]   = ev[EV_MEM_LOGIC];
        flag_set[FL_OTHER] = ev[EV_OTHER];
        flag_set[FL_CMD]   = bad_cmd;
        flags_nxt = (clear_faults_i ? '0 : flags_r) | flag_set;
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= {FL_COUNT{FLAG_RESET}};
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign overvoltage_fault_flag_r             = flags_r[FL_OVF];
    assign overvoltage_warning_flag_r           = flags_r[FL_OVW];
    assign undervoltage_warning_flag_r          = flags_r[FL_UVW];
    assign undervoltage_fault_flag_r            = flags_r[FL_UVF];
    assign positive_overcurrent_flag_r          = flags_r[FL_OCP];
    assign overcurrent_with_undervoltage_flag_r = flags_r[FL_OCUV];
    assign negative_overcurrent_flag_r          = flags_r[FL_OCN];
    assign bias_fault_r                         = flags_r[FL_BIAS];
    assign temp_fault_r                         = flags_r[FL_TEMP];
    assign mem_logic_fault_r                    = flags_r[FL_MEM];
    assign other_fault_r                        = flags_r[FL_OTHER];
    assign cmd_fault_r                          = flags_r[FL_CMD];

    // ------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------
    // Unused positions stay at the zero of BYTE_RESET
    logic [7:0] output_voltage_summary_detail;
    logic [7:0] output_current_summary_detail;
    logic [7:0] summary_low;
    logic [7:0] summary_high;

    always_comb begin
        output_voltage_summary_detail = BYTE_RESET;
        output_voltage_summary_detail[VD_OVF_BIT] = overvoltage_fault_flag_r;
        output_voltage_summary_detail[VD_OVW_BIT] = overvoltage_warning_flag_r;
        output_voltage_summary_detail[VD_UVW_BIT] = undervoltage_warning_flag_r;
        output_voltage_summary_detail[VD_UVF_BIT] = undervoltage_fault_flag_r;
    end

    always_comb begin
        output_current_summary_detail = BYTE_RESET;
        output_current_summary_detail[ID_OCF_BIT]   = positive_overcurrent_flag_r;
        output_current_summary_detail[ID_OVERCURRENT_WITH_UNDERVOLTAGE_FLAG_BIT] =
            overcurrent_with_undervoltage_flag_r;
        output_current_summary_detail[ID_UCF_BIT]   = negative_overcurrent_flag_r;
    end

    // High summary bits 7 and 6 are built from the detail images; bit 5 reads the bias flag and bit 3 the live pin level
    always_comb begin
        summary_high = BYTE_RESET;
        summary_high[HI_OUTPUT_VOLTAGE_SUMMARY_BIT]  = |output_voltage_summary_detail;
        summary_high[HI_OUTPUT_CURRENT_SUMMARY_BIT]  = |output_current_summary_detail;
        summary_high[HI_BIAS_BIT]  = bias_fault_r;
        // Live pin level, not latched: reads 1 while the pin is low;
        // the chain resets to 0, so it also reads 1 just after reset
        summary_high[HI_POWER_GOOD_LOW_FLAG_BIT] = !ev[EV_POWER_GOOD_LOW_FLAG_PIN];
    end

    always_comb begin
        summary_low = BYTE_RESET;
        // Over-voltage and over-current keep driving, so only the
        // command and tri-state response decide this bit
        summary_low[LO_OFF_BIT] =
            !commanded_on_i || output_tristated_i;
        summary_low[LO_OV_BIT]     = overvoltage_fault_flag_r;
        summary_low[LO_OC_BIT]     = positive_overcurrent_flag_r;
        summary_low[LO_VIN_UV_BIT] = bias_fault_r;
        summary_low[LO_TEMP_BIT]   = temp_fault_r;
        summary_low[LO_CML_BIT]    =
            mem_logic_fault_r || cmd_fault_r;
        summary_low[LO_OTHER_BIT]  = other_fault_r;
    end

    // ------------------------------------------------------------------
    // Command read port
    // ------------------------------------------------------------------
    // Writes are accepted and dropped; wdata has no path to any flag.
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic       rd_valid_r;
    logic       rd_valid_nxt;
    logic       wdata_unused;

    assign wdata_unused = ^cmd_wdata_i;

    always_comb begin
        rd_data_nxt  = rd_data_r;
        rd_valid_nxt = 1'b0;
        if (cmd_valid_i && !cmd_write_i && claimed) begin
            rd_valid_nxt = 1'b1;
            unique case (cmd_code_i)
                CMD_SUMMARY_LOW:  rd_data_nxt = summary_low;
                CMD_SUMMARY_HIGH: rd_data_nxt = summary_high;
                CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL:  rd_data_nxt = output_voltage_summary_detail;
                CMD_OUTPUT_CURRENT_SUMMARY_DETAIL:  rd_data_nxt = output_current_summary_detail;
                default:          rd_data_nxt = BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r  <= BYTE_RESET;
            rd_valid_r <= FLAG_RESET;
        end else begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data_o       = rd_data_r;
    assign rd_valid_o      = rd_valid_r;
    // Claim is combinational so the bus engine can act in the same cycle
    assign cmd_claimed_o   = cmd_valid_i && claimed;
    assign command_fault_o = cmd_fault_r;

endmodule

// [dv/fault_status_monitor.sv]
// Port-level checks for the fault status register bank
`timescale 1ns/1ps
module fault_status_monitor (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    // Command port and state inputs
    input wire logic       cmd_valid_i,
    input wire logic       cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic       cmd_known_elsewhere_i,
    input wire logic       clear_faults_i,
    input wire logic       commanded_on_i,
    input wire logic       output_tristated_i,
    // Answers
    input wire logic [7:0] rd_data_o,
    input wire logic       rd_valid_o,
    input wire logic       cmd_claimed_o,
    input wire logic       command_fault_o
);
    import fault_status_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic in_rng;
    logic rd_hit;
    assign in_rng = cmd_code_i >= CMD_SUMMARY_LOW
                 && cmd_code_i <= CMD_OUTPUT_CURRENT_SUMMARY_DETAIL;
    assign rd_hit = cmd_valid_i && !cmd_write_i && in_rng;

    chk_no_stray_answer: assert property (
        !rd_hit |=> !rd_valid_o) else $error("answer without read");
    chk_data_holds: assert property (
        !rd_valid_o |-> $stable(rd_data_o)) else $error("data moved");
    chk_output_voltage_summary_unused: assert property (
        rd_hit && cmd_code_i == CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL |=> rd_data_o[3:0] == 4'h0)
        else $error("voltage detail low nibble set");
    chk_output_current_summary_unused: assert property (
        rd_hit && cmd_code_i == CMD_OUTPUT_CURRENT_SUMMARY_DETAIL
        |=> rd_data_o[5] == 1'h0 && rd_data_o[3:0] == 4'h0)
        else $error("current detail unused bit set");
    chk_high_unused: assert property (
        rd_hit && cmd_code_i == CMD_SUMMARY_HIGH
        |=> rd_data_o[4] == 1'h0 && rd_data_o[2:0] == 3'h0)
        else $error("high byte unused bit set");
    chk_low_unused: assert property (
        rd_hit && cmd_code_i == CMD_SUMMARY_LOW |=> !rd_data_o[7])
        else $error("low byte bit 7 set");
    chk_off_bit: assert property (
        rd_hit && cmd_code_i == CMD_SUMMARY_LOW && $stable(commanded_on_i)
        && $stable(output_tristated_i) |=> rd_data_o[6] ==
        (!$past(commanded_on_i) || $past(output_tristated_i)))
        else $error("off bit wrong");
    chk_cmd_fault_set: assert property (
        cmd_valid_i && !in_rng && !cmd_known_elsewhere_i && !clear_faults_i
        |=> command_fault_o) else $error("command fault not raised");
    chk_fault_sticky: assert property (
        command_fault_o && !clear_faults_i |=> command_fault_o)
        else $error("command fault dropped");
    chk_cml_shows: assert property (
        rd_hit && cmd_code_i == CMD_SUMMARY_LOW && command_fault_o
        |=> rd_data_o[1]) else $error("comm fault bit missing");
    chk_read_answered: assert property (
        rd_hit |=> rd_valid_o) else $error("read not answered");
    chk_claim_match: assert property (
        cmd_claimed_o == (cmd_valid_i && in_rng))
        else $error("claim flag wrong");
endmodule

// [dv/host_cmd_model.sv]
// Host-side command source for the status register bank
`timescale 1ns/1ps
module host_cmd_model (
    // Clock
    input  wire logic       clk_i,
    // Command outputs
    output logic       cmd_valid_o,
    output logic       cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] cmd_wdata_o,
    output logic       cmd_known_o,
    output logic       clear_o,
    // Answer inputs
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i
);
    initial begin
        cmd_valid_o = 1'h0;
        cmd_write_o = 1'h0;
        cmd_code_o  = 8'h00;
        cmd_wdata_o = 8'h00;
        cmd_known_o = 1'h0;
        clear_o     = 1'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] code,
                        input logic known, input logic [7:0] wd,
                        output logic [7:0] d, output logic got);
        int n;
        @(posedge clk_i);
        cmd_valid_o <= 1'h1;
        cmd_write_o <= wr;
        cmd_code_o  <= code;
        cmd_wdata_o <= wd;
        cmd_known_o <= known;
        @(posedge clk_i);
        // Released lines show garbage, not the last value
        cmd_valid_o <= 1'h0;
        cmd_code_o  <= ~code;
        cmd_wdata_o <= ~wd;
        cmd_known_o <= ~known;
        got = 1'h0;
        d   = 8'h00;
        for (n = 0; n < 3 && !got; n++) begin
            @(posedge clk_i);
            if (rd_valid_i === 1'h1) begin
                got = 1'h1;
                d   = rd_data_i;
            end
        end
    endtask
    task automatic clr();
        @(posedge clk_i);
        clear_o <= 1'h1;
        @(posedge clk_i);
        clear_o <= 1'h0;
    endtask
endmodule

// [dv/fault_status_regs_tb.sv]
// Self-checking bench for the fault status register bank
`timescale 1ns/1ps
module fault_status_regs_tb;
    import fault_status_pkg::*;
    logic              clk_i = 1'h0;
    logic              rst_b_i = 1'h0;
    logic [10:0]       ev = 11'h400;
    logic              cmd_on = 1'h1;
    logic              tri_s = 1'h0;
    logic              cv, cw, ck, cl, rv, cf, got;
    logic [7:0]        cc, cd, rd, d;
    logic [9:0]        lat = 10'h000;
    logic              ocuv = 1'h0;
    logic              cmdf = 1'h0;
    int                n_mismatch = 0;
    int                checks = 0;
    integer            seed = 32'h93DE;

    fault_status_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .event_i(ev), .commanded_on_i(cmd_on), .output_tristated_i(tri_s),
        .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_code_i(cc),
        .cmd_wdata_i(cd), .cmd_known_elsewhere_i(ck), .clear_faults_i(cl),
        .rd_data_o(rd), .rd_valid_o(rv), .cmd_claimed_o(),
        .command_fault_o(cf));
    host_cmd_model i_host (.clk_i(clk_i), .cmd_valid_o(cv),
        .cmd_write_o(cw), .cmd_code_o(cc), .cmd_wdata_o(cd),
        .cmd_known_o(ck), .clear_o(cl), .rd_data_i(rd), .rd_valid_i(rv));

    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // -------------------------------------------
    // Expectation, comparison and closing
    // -------------------------------------------
    function automatic logic [7:0] exp_reg(input logic [7:0] c);
        logic [7:0] vd, id;
        vd = {lat[EV_OVF], lat[EV_OVW], lat[EV_UVW], lat[EV_UVF], 4'h0};
        id = {lat[EV_OCP], ocuv, 1'h0, lat[EV_OCN], 4'h0};
        if (c == CMD_OUTPUT_VOLTAGE_SUMMARY_DETAIL) return vd;
        if (c == CMD_OUTPUT_CURRENT_SUMMARY_DETAIL) return id;
        if (c == CMD_SUMMARY_HIGH)
            return {|vd, |id, lat[EV_BIAS_UV], 1'h0, ~ev[EV_POWER_GOOD_LOW_FLAG_PIN], 3'h0};
        return {1'h0, ~cmd_on | tri_s, lat[EV_OVF], lat[EV_OCP],
            lat[EV_BIAS_UV], lat[EV_TEMP], lat[EV_MEM_LOGIC] | cmdf,
            lat[EV_OTHER]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_all();
        for (int c = 0; c < 4; c++) begin
            i_host.xfer(1'h0, 8'h78 + c[7:0], 1'h0, 8'($random(seed)),
                        d, got);
            check({7'h0, got}, 8'h01);
            check(d, exp_reg(8'h78 + c[7:0]));
        end
    endtask
    task automatic ev_apply(input logic [10:0] v);
        @(posedge clk_i);
        ev <= v;
        lat = lat | v[9:0];
        ocuv = ocuv | (v[EV_OCP] & v[EV_UVF]);
        repeat (4) @(posedge clk_i);
        ev <= {v[10], 10'h000};
        repeat (4) @(posedge clk_i);
    endtask
    task automatic clear_all();
        i_host.clr();
        lat = 10'h000;
        ocuv = 1'h0;
        cmdf = 1'h0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // -------------------------------------------
    // Scenarios
    // -------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rd_all();
        $display("done: reset image");
        for (int i = 0; i < 10; i++) begin
            ev_apply(11'h400 | (11'h001 << i));
            rd_all();
            rd_all();
            clear_all();
        end
        ev_apply(11'h418);
        rd_all();
        $display("done: single events");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            {cmd_on, tri_s} <= k[1:0];
            repeat (2) @(posedge clk_i);
            rd_all();
        end
        ev_apply(11'h000);
        rd_all();
        ev_apply(11'h400);
        $display("done: off and power-good");
        for (int c = 0; c < 4; c++) begin
            i_host.xfer(1'h1, 8'h78 + c[7:0], 1'h0, 8'hFF, d, got);
            check({7'h0, got}, 8'h00);
        end
        rd_all();
        i_host.xfer(1'h0, 8'h55, 1'h1, 8'h00, d, got);
        check({7'h0, cf}, 8'h00);
        i_host.xfer(1'h1, 8'h90, 1'h0, 8'h3C, d, got);
        cmdf = 1'h1;
        check({7'h0, cf, got}, 8'h02);
        rd_all();
        clear_all();
        $display("done: writes and bad codes");
        for (int r = 0; r < 30; r++) begin
            ev_apply(11'($random(seed)));
            rd_all();
            if (r % 7 == 6) clear_all();
        end
        $display("done: random events");
        finish_test();
    end
    initial begin
        #(50 * 20000);
        n_mismatch++;
        finish_test();
    end
endmodule

bind fault_status_regs fault_status_monitor i_mon (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
    .cmd_code_i(cmd_code_i), .cmd_known_elsewhere_i(cmd_known_elsewhere_i),
    .clear_faults_i(clear_faults_i), .commanded_on_i(commanded_on_i),
    .output_tristated_i(output_tristated_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .cmd_claimed_o(cmd_claimed_o),
    .command_fault_o(command_fault_o));
